// File: logic/rtc_ext_ctrl.sv
// Extended control/status registers and address recovery stack.
// Assumes bank_select_i comes from register A logic on clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_ext_params.svh"
module rtc_ext_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Multiplexed host bus pins
  input wire logic [7:0] ad_i,
  output logic [7:0] ad_o,
  output logic ad_oe_o,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cs_n_i,
  // Bank select from register A
  input wire logic bank_select_i,
  // Device pins
  input wire logic kick_in_n_i,
  input wire logic ram_wipe_in_n_i,
  input wire logic vcc_ok_i,
  input wire logic aux_battery_valid_i,
  input wire logic osc_32k_i,
  output logic power_on_out_o,
  output logic power_on_out_oe_o,
  output logic system_mgmt_irq_o,
  output logic system_mgmt_irq_oe_o,
  output logic square_out_o,
  output logic aux_supply_pin_en_o,
  output logic xtal_load_sel_o,
  // Timekeeping side
  input wire logic update_request_i,
  input wire logic update_done_i,
  input wire logic wake_match_i,
  output logic update_go_o,
  // User RAM wipe and extended RAM side
  output logic ram_wipe_we_o,
  output logic [6:0] ram_wipe_addr_o,
  output logic xram_addr_inc_o
);
  // ============================================================
  // Declarations
  pin_sync_if sy ();
  logic [7:0] addr_ff;
  logic [7:0] stat_ff;
  logic [7:0] en_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [10:0] lead_cnt_ff;
  logic [6:0] wipe_cnt_ff;
  logic [7:0] stk_prev;
  logic [7:0] stk_older;
  logic [7:0] din;
  logic rd_act;
  logic wr_done;
  logic rd_done;
  logic hit;
  logic wr_stat;
  logic wr_en;
  logic wake_set;
  logic kick_set;
  logic wipe_fin;
  logic wake_armed;
  logic kick_armed;
  logic vcc;
  rtc_ext_pkg::upd_state_t upd_ff;
  rtc_ext_pkg::wipe_state_t wipe_ff;

  // ============================================================
  // Pin synchronisation
  pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i({ad_i, osc_32k_i, aux_battery_valid_i, vcc_ok_i, ram_wipe_in_n_i,
      kick_in_n_i, cs_n_i, wr_n_i, rd_n_i, ale_i}),
    .sy(sy.src)
  );

  // Bus strobes, all after synchronisation
  assign din = sy.lvl[`PIN_AD +: 8];
  assign vcc = sy.lvl[`PIN_VCC];
  assign rd_act = ~sy.lvl[`PIN_RD] & ~sy.lvl[`PIN_CS];
  assign wr_done = sy.rise[`PIN_WR] & ~sy.lvl[`PIN_CS];
  assign rd_done = sy.rise[`PIN_RD] & ~sy.lvl[`PIN_CS];

  // ============================================================
  // Address latch; also the stack push
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      addr_ff <= 8'h00;
    else if (sy.fall[`PIN_ALE])
      addr_ff <= din;
  end

  addr_stack u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(sy.fall[`PIN_ALE]),
    .addr_i(din),
    .prev_o(stk_prev),
    .older_o(stk_older)
  );

  // ============================================================
  // Decode: only in bank one; 0Ah handling lives in register A
  assign hit = bank_select_i && (addr_ff == `OFS_EXT_STAT || addr_ff == `OFS_EXT_EN ||
    addr_ff == `OFS_STK_OLDER || addr_ff == `OFS_STK_PREV);
  assign wr_stat = wr_done && bank_select_i && addr_ff == `OFS_EXT_STAT;
  assign wr_en = wr_done && bank_select_i && addr_ff == `OFS_EXT_EN;

  // Read mux; bit 4 of the status register is held at zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (addr_ff)
      `OFS_EXT_STAT: nxt_rdata = stat_ff;
      `OFS_EXT_EN: nxt_rdata = en_ff;
      `OFS_STK_OLDER: nxt_rdata = stk_older;
      `OFS_STK_PREV: nxt_rdata = stk_prev;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Registered read data so the bus sees a clean value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end
  assign ad_o = rdata_ff;
  assign ad_oe_o = rd_act & hit;

  // ============================================================
  // Event sources
  assign wake_set = wake_match_i;
  assign kick_set = sy.fall[`PIN_KICK];
  assign wake_armed = stat_ff[`B_WAKEF] & en_ff[`B_WAKEIE];
  assign kick_armed = stat_ff[`B_KICKF] & en_ff[`B_KICKIE];
  assign wipe_fin = (wipe_ff == rtc_ext_pkg::WIPE_BUSY) && (wipe_cnt_ff == `WIPE_BYTES - 7'h01);

  // ============================================================
  // Status flags: hardware set wins over a software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_ff[2:0] <= 3'h0;
    else
    begin
      stat_ff[`B_KICKF] <= kick_set | (wr_stat ? din[`B_KICKF] : stat_ff[`B_KICKF]);
      stat_ff[`B_WAKEF] <= wake_set | (wr_stat ? din[`B_WAKEF] : stat_ff[`B_WAKEF]);
      stat_ff[`B_WIPEF] <= wipe_fin | (wr_stat ? din[`B_WIPEF] : stat_ff[`B_WIPEF]);
    end
  end

  // Release bit: armed events and power fail beat software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_ff[`B_RELEASE] <= 1'b1;
    else if (wake_armed | kick_armed)
      stat_ff[`B_RELEASE] <= 1'b0;
    else if (sy.fall[`PIN_VCC] & ~en_ff[`B_HOLD])
      stat_ff[`B_RELEASE] <= 1'b1;
    else if (wr_stat)
      stat_ff[`B_RELEASE] <= din[`B_RELEASE];
  end

  // Burst enable, reserved bit and live status bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_ff[`B_BURST] <= 1'b0;
      stat_ff[`B_RSVD] <= 1'b0;
      stat_ff[`B_AUXBAT] <= 1'b0;
      stat_ff[`B_UPDPEND] <= 1'b0;
    end
    else
    begin
      if (wr_stat)
        stat_ff[`B_BURST] <= din[`B_BURST];
      stat_ff[`B_RSVD] <= 1'b0;
      stat_ff[`B_AUXBAT] <= sy.lvl[`PIN_AUXBAT];
      // Follows the next state, so it rises with the lead phase and not one cycle late
      stat_ff[`B_UPDPEND] <= (upd_ff == rtc_ext_pkg::UPD_IDLE) ? update_request_i :
        !(upd_ff == rtc_ext_pkg::UPD_RUN && update_done_i);
    end
  end

  // ============================================================
  // Enable register; oscillator output re-armed on mains return
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      en_ff <= `RST_EN;
    else
    begin
      if (wr_en)
        en_ff <= din;
      if (sy.rise[`PIN_VCC])
        en_ff[`B_OSCEN] <= 1'b1;
    end
  end

  // ============================================================
  // Update pending: lead time then wait for the update to finish
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      upd_ff <= rtc_ext_pkg::UPD_IDLE;
      lead_cnt_ff <= 11'h000;
    end
    else
    begin
      unique case (upd_ff)
        rtc_ext_pkg::UPD_IDLE:
          if (update_request_i)
          begin
            upd_ff <= rtc_ext_pkg::UPD_LEAD;
            lead_cnt_ff <= 11'h000;
          end
        rtc_ext_pkg::UPD_LEAD:
          if (lead_cnt_ff == 11'(`UPD_LEAD_CYC - 1))
            upd_ff <= rtc_ext_pkg::UPD_RUN;
          else
            lead_cnt_ff <= lead_cnt_ff + 11'h001;
        rtc_ext_pkg::UPD_RUN:
          if (update_done_i)
            upd_ff <= rtc_ext_pkg::UPD_IDLE;
      endcase
    end
  end
  assign update_go_o = (upd_ff == rtc_ext_pkg::UPD_LEAD) && (lead_cnt_ff == 11'(`UPD_LEAD_CYC - 1));

  // ============================================================
  // User RAM wipe: one byte per cycle, ignored unless enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wipe_ff <= rtc_ext_pkg::WIPE_IDLE;
      wipe_cnt_ff <= 7'h00;
    end
    else
    begin
      unique case (wipe_ff)
        rtc_ext_pkg::WIPE_IDLE:
          if (sy.fall[`PIN_WIPE] & en_ff[`B_WIPEEN])
          begin
            wipe_ff <= rtc_ext_pkg::WIPE_BUSY;
            wipe_cnt_ff <= 7'h00;
          end
        rtc_ext_pkg::WIPE_BUSY:
          if (wipe_fin)
            wipe_ff <= rtc_ext_pkg::WIPE_IDLE;
          else
            wipe_cnt_ff <= wipe_cnt_ff + 7'h01;
      endcase
    end
  end
  assign ram_wipe_we_o = (wipe_ff == rtc_ext_pkg::WIPE_BUSY);
  assign ram_wipe_addr_o = wipe_cnt_ff;

  // ============================================================
  // Pin outputs; open-drain pins only ever pull low
  assign power_on_out_o = 1'b0;
  assign power_on_out_oe_o = ~stat_ff[`B_RELEASE];
  assign system_mgmt_irq_o = 1'b0;
  // Interrupt only with mains present, so it follows power-up
  assign system_mgmt_irq_oe_o = vcc & ((stat_ff[`B_WIPEF] & en_ff[`B_WIPEIE]) |
    wake_armed | kick_armed);
  assign aux_supply_pin_en_o = en_ff[`B_AUXEN];
  assign xtal_load_sel_o = en_ff[`B_XTAL];
  // Burst step on the trailing strobe edge of a data access
  assign xram_addr_inc_o = stat_ff[`B_BURST] & bank_select_i &
    (addr_ff == `OFS_XRAM_DATA) & (rd_done | wr_done);

  // Square output from a flop; jitter of one clock is accepted
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      square_out_o <= 1'b0;
    else
      square_out_o <= sy.lvl[`PIN_OSC] & en_ff[`B_OSCEN];
  end

  // ============================================================
  // Assertions
  logic [10:0] seen_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || upd_ff == rtc_ext_pkg::UPD_IDLE)
      seen_ff <= 11'h000;
    else if (upd_ff == rtc_ext_pkg::UPD_LEAD)
      seen_ff <= seen_ff + 11'h001;
  end

  property p_upd_lead;
    @(posedge clk_i) disable iff (rst_i)
    update_go_o |-> seen_ff == 11'(`UPD_LEAD_CYC - 1) && upd_ff == rtc_ext_pkg::UPD_LEAD;
  endproperty
  a_upd_lead: assert property (p_upd_lead) else $error("update lead time wrong");

  property p_pend;
    @(posedge clk_i) disable iff (rst_i)
    update_go_o |-> ##2 stat_ff[`B_UPDPEND];
  endproperty
  a_pend: assert property (p_pend) else $error("pending not shown");

  property p_pend_lead;
    @(posedge clk_i) disable iff (rst_i)
    $rose(upd_ff == rtc_ext_pkg::UPD_LEAD) |-> stat_ff[`B_UPDPEND];
  endproperty
  a_pend_lead: assert property (p_pend_lead) else $error("pending late");

  property p_kick;
    @(posedge clk_i) disable iff (rst_i)
    sy.fall[`PIN_KICK] |=> stat_ff[`B_KICKF];
  endproperty
  a_kick: assert property (p_kick) else $error("kick flag not set");

  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
    wake_match_i && en_ff[`B_WAKEIE] |=> ##1 !stat_ff[`B_RELEASE] && power_on_out_oe_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not drive power");

  property p_pwr;
    @(posedge clk_i) disable iff (rst_i)
    power_on_out_oe_o == !stat_ff[`B_RELEASE] && !power_on_out_o;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power pin mismatch");

  property p_fail;
    @(posedge clk_i) disable iff (rst_i)
    sy.fall[`PIN_VCC] && !en_ff[`B_HOLD] && !wake_armed && !kick_armed |=> !power_on_out_oe_o;
  endproperty
  a_fail: assert property (p_fail) else $error("power kept through fail");

  property p_wipe;
    @(posedge clk_i) disable iff (rst_i)
    $rose(ram_wipe_we_o) |-> ##113 (ram_wipe_we_o && ram_wipe_addr_o == 7'h71) ##1
      (!ram_wipe_we_o && stat_ff[`B_WIPEF]);
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe length wrong");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    vcc && stat_ff[`B_WIPEF] && en_ff[`B_WIPEIE] |-> system_mgmt_irq_oe_o;
  endproperty
  a_irq: assert property (p_irq) else $error("wipe irq missing");

  property p_noburst;
    @(posedge clk_i) disable iff (rst_i)
    !stat_ff[`B_BURST] || addr_ff != `OFS_XRAM_DATA |-> !xram_addr_inc_o;
  endproperty
  a_noburst: assert property (p_noburst) else $error("burst step unexpected");

  property p_push;
    @(posedge clk_i) disable iff (rst_i)
    sy.fall[`PIN_ALE] |=> stk_prev == $past(addr_ff) && stk_older == $past(stk_prev);
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong");

  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    ad_oe_o && $past(addr_ff) == `OFS_EXT_STAT |-> !ad_o[`B_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  c_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_armed ##1 system_mgmt_irq_oe_o);
  c_wipe: cover property (@(posedge clk_i) disable iff (rst_i) $fell(ram_wipe_we_o));
  c_burst: cover property (@(posedge clk_i) disable iff (rst_i) xram_addr_inc_o);
endmodule // rtc_ext_ctrl
`default_nettype wire

// File: logic/rtc_ext_params.svh
// Constants for the extended control and address stack block.
// Assumes a 10 MHz core clock.
`ifndef RTC_EXT_PARAMS_SVH
`define RTC_EXT_PARAMS_SVH
// ============================================================
// Register offsets
`define OFS_EXT_STAT 8'h4a
`define OFS_EXT_EN 8'h4b
`define OFS_STK_OLDER 8'h4e
`define OFS_STK_PREV 8'h4f
`define OFS_XRAM_DATA 8'h53
// ============================================================
// Status/control field positions
`define B_AUXBAT 7
`define B_UPDPEND 6
`define B_BURST 5
`define B_RSVD 4
`define B_RELEASE 3
`define B_WIPEF 2
`define B_WAKEF 1
`define B_KICKF 0
// ============================================================
// Enable register field positions
`define B_AUXEN 7
`define B_OSCEN 6
`define B_XTAL 5
`define B_WIPEEN 4
`define B_HOLD 3
`define B_WIPEIE 2
`define B_WAKEIE 1
`define B_KICKIE 0
// ============================================================
// Reset values
`define RST_STAT 8'h08
`define RST_EN 8'h40
// ============================================================
// Pin index in the synchroniser vector
`define PIN_ALE 0
`define PIN_RD 1
`define PIN_WR 2
`define PIN_CS 3
`define PIN_KICK 4
`define PIN_WIPE 5
`define PIN_VCC 6
`define PIN_AUXBAT 7
`define PIN_OSC 8
`define PIN_AD 9
`define PIN_N 17
// ============================================================
// Timing and sizes
`define CLK_PERIOD_NS 100
`define UPD_LEAD_NS 122000
`define UPD_LEAD_CYC ((`UPD_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIPE_BYTES 7'h72
`define STACK_DEPTH 4
`endif

// File: logic/rtc_ext_pkg.sv
// Types shared by the extended control block.
// Assumes rtc_ext_params.svh for numeric constants.
package rtc_ext_pkg;
  typedef enum logic [1:0] {UPD_IDLE, UPD_LEAD, UPD_RUN} upd_state_t;
  typedef enum logic {WIPE_IDLE, WIPE_BUSY} wipe_state_t;
endpackage

// File: logic/pin_sync_if.sv
// Carrier for synchronised pin levels and their edges.
// Assumes one core clock for producer and consumer.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_ext_params.svh"
interface pin_sync_if;
  logic [`PIN_N-1:0] lvl;
  logic [`PIN_N-1:0] rise;
  logic [`PIN_N-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// File: logic/pin_sync.sv
// Two-flop synchronisers with edge detection for all pins.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_ext_params.svh"
module pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pins
  input wire logic [`PIN_N-1:0] raw_i,
  // Synchronised view
  pin_sync_if.src sy
);
  // ============================================================
  // Per-pin synchroniser; edges look only at stages two and three
  genvar g;
  generate
    for (g = 0; g < `PIN_N; g++)
    begin : g_pin
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      always_ff @(posedge clk_i)
      begin
        s1_ff <= raw_i[g];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
      end
      assign sy.lvl[g] = s2_ff;
      assign sy.rise[g] = s2_ff & ~s3_ff & ~rst_i;
      assign sy.fall[g] = ~s2_ff & s3_ff & ~rst_i;
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

// File: logic/addr_stack.sv
// Four-deep shift stack of latched register addresses.
// Assumes push is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_ext_params.svh"
module addr_stack (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Push side
  input wire logic push_i,
  input wire logic [7:0] addr_i,
  // Read side
  output logic [7:0] prev_o,
  output logic [7:0] older_o
);
  logic [7:0] ent_ff [`STACK_DEPTH];
  // ============================================================
  // Shift on push; the oldest entry falls off the end
  genvar g;
  generate
    for (g = 0; g < `STACK_DEPTH; g++)
    begin : g_ent
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          ent_ff[g] <= 8'h00;
        else if (push_i)
          ent_ff[g] <= (g == 0) ? addr_i : ent_ff[(g == 0) ? 0 : g - 1];
      end
    end
  endgenerate
  assign prev_o = ent_ff[1];
  assign older_o = ent_ff[2];
endmodule // addr_stack
`default_nettype wire

// File: verification/host_bus_model.sv
// Host processor model for the multiplexed address/data bus.
// Assumes one clock shared with the device; drives only at rising edges.
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  // Clock
  input wire logic clk_i,
  // Device answer
  input wire logic [7:0] dev_ad_i,
  input wire logic dev_oe_i,
  // Bus lines
  output logic [7:0] ad_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cs_n_o
);
  logic [7:0] drv_ff;
  logic host_oe_ff;
  // ============================================================
  // Wire level; a floating bus shows the inverse of the last value
  assign ad_o = dev_oe_i ? dev_ad_i : (host_oe_ff ? drv_ff : ~drv_ff);
  // Idle bus at time zero
  initial
  begin
    drv_ff = 8'h00;
    host_oe_ff = 1'b0;
    ale_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
  end
  // ============================================================
  // Address phase; strobes 3 clk apart because pins pass two flops
  task automatic latch(input logic [7:0] a);
    @(posedge clk_i);
    drv_ff <= a;
    host_oe_ff <= 1'b1;
    ale_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    ale_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // Write cycle; data held well across the strobe rise
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    latch(a);
    drv_ff <= d;
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    cs_n_o <= 1'b1;
    host_oe_ff <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Read cycle; bus released, answer taken once settled
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d, output logic hit);
    latch(a);
    host_oe_ff <= 1'b0;
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    d = dev_ad_i;
    hit = dev_oe_i;
    @(posedge clk_i);
    // Chip select outlasts the strobe so its trailing edge is seen
    rd_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
endmodule // host_bus_model
`default_nettype wire

// File: verification/rtc_extended_control_and_smi_stack_tb_top.sv
// Bench for the extended control registers and address stack.
// Assumes the host model owns the bus; this module drives the other pins.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_ext_params.svh"
module rtc_extended_control_and_smi_stack_tb_top;
  typedef struct packed {logic [1:0] op; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp; logic hit;} row_t;
  logic clk_i, rst_i, ad_oe, ale, rd_n, wr_n, cs_n, bank, kick_n, wipe_n, vcc, aux_bat, osc;
  logic upd_req, upd_done, wake, pwr_oe, irq_oe, sq, aux_en, xtal, upd_go, we, inc, h, pwr_lvl, irq_lvl;
  logic [7:0] ad, ad_q, d;
  logic [6:0] waddr, last;
  logic [5:0] mon;
  logic [2:0] osc_cnt;
  int checks, failures, inc_cnt, base, n;
  // Op 0 read, 1 write then read, 2 address latch only
  row_t rows [11] = '{
    '{2'd0, 8'h4a, 8'h00, 8'h88, 1'b1},
    '{2'd0, 8'h4b, 8'h00, 8'h40, 1'b1},
    '{2'd1, 8'h4a, 8'hff, 8'haf, 1'b1},
    '{2'd1, 8'h4a, 8'h00, 8'h80, 1'b1},
    '{2'd1, 8'h4b, 8'ha5, 8'ha5, 1'b1},
    '{2'd1, 8'h4e, 8'h12, 8'h4b, 1'b1},
    '{2'd2, 8'h4b, 8'h00, 8'h00, 1'b1},
    '{2'd2, 8'h0a, 8'h00, 8'h00, 1'b1},
    '{2'd0, 8'h4e, 8'h00, 8'h4b, 1'b1},
    '{2'd0, 8'h4f, 8'h00, 8'h4e, 1'b1},
    '{2'd0, 8'h4c, 8'h00, 8'h00, 1'b0}
  };
  // ============================================================
  // Design, host and pin stimulus
  rtc_ext_ctrl rtc_ext_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ad_i(ad), .ad_o(ad_q), .ad_oe_o(ad_oe), .ale_i(ale),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .cs_n_i(cs_n), .bank_select_i(bank), .kick_in_n_i(kick_n),
    .ram_wipe_in_n_i(wipe_n), .vcc_ok_i(vcc), .aux_battery_valid_i(aux_bat), .osc_32k_i(osc),
    .power_on_out_o(pwr_lvl), .power_on_out_oe_o(pwr_oe), .system_mgmt_irq_o(irq_lvl),
    .system_mgmt_irq_oe_o(irq_oe), .square_out_o(sq), .aux_supply_pin_en_o(aux_en),
    .xtal_load_sel_o(xtal), .update_request_i(upd_req), .update_done_i(upd_done),
    .wake_match_i(wake), .update_go_o(upd_go), .ram_wipe_we_o(we), .ram_wipe_addr_o(waddr),
    .xram_addr_inc_o(inc));
  host_bus_model host_bus_model_inst (.clk_i(clk_i), .dev_ad_i(ad_q), .dev_oe_i(ad_oe),
    .ad_o(ad), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n));
  // Outputs watched by the bounded waits
  assign mon = {sq, ~pwr_oe, we, upd_go, irq_oe, pwr_oe};
  // Clock, 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Fast stand-in oscillator; real rate would make the run long
  always @(posedge clk_i)
  begin
    osc_cnt <= osc_cnt + 3'h1;
    if (osc_cnt == 3'h7)
      osc <= ~osc;
  end
  // Burst increment pulse counter
  always @(posedge clk_i)
    if (inc === 1'b1)
      inc_cnt <= inc_cnt + 1;
  // ============================================================
  // Helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_bus_model_inst.bus_read(a, d, h);
    check(16'(h), 16'h0001);
    check(16'(d), 16'(exp));
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_bus_model_inst.bus_write(a, v);
  endtask
  // Bounded wait on a monitor bit, counted in cycles
  task automatic wait_bit(input int b, input int lim);
    n = 0;
    @(negedge clk_i);
    while (mon[b] !== 1'b1 && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    if (mon[b] !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      print_verdict();
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    bank = 1'b1;
    kick_n = 1'b1;
    wipe_n = 1'b1;
    vcc = 1'b1;
    aux_bat = 1'b1;
    osc = 1'b0;
    osc_cnt = 3'h0;
    upd_req = 1'b0;
    upd_done = 1'b0;
    wake = 1'b0;
    checks = 0;
    failures = 0;
    inc_cnt = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    foreach (rows[i])
    begin
      if (rows[i].op == 2'd2)
        host_bus_model_inst.latch(rows[i].addr);
      else
      begin
        if (rows[i].op == 2'd1)
          wr(rows[i].addr, rows[i].wdata);
        host_bus_model_inst.bus_read(rows[i].addr, d, h);
        check(16'(h), 16'(rows[i].hit));
        if (rows[i].hit)
          check(16'(d), 16'(rows[i].exp));
      end
    end
    check(16'({aux_en, xtal, pwr_oe}), 16'h0007);
    done("table");
    // Kick with enable set; flags cleared before release is set
    wr(8'h4b, 8'h41);
    wr(8'h4a, 8'h08);
    check(16'(pwr_oe), 16'h0000);
    kick_n <= 1'b0;
    repeat (20) @(posedge clk_i);
    kick_n <= 1'b1;
    wait_bit(0, 20);
    check(16'({pwr_lvl, irq_lvl, irq_oe}), 16'h0001);
    rd(8'h4a, 8'h81);
    wr(8'h4a, 8'h00);
    wr(8'h4a, 8'h08);
    check(16'({irq_oe, pwr_oe}), 16'h0000);
    // Wake with enable clear, then arming it
    wr(8'h4b, 8'h40);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(16'({irq_oe, pwr_oe}), 16'h0000);
    rd(8'h4a, 8'h8a);
    wr(8'h4b, 8'h42);
    wait_bit(0, 10);
    check(16'(irq_oe), 16'h0001);
    wr(8'h4b, 8'h40);
    wr(8'h4a, 8'h08);
    done("events");
    // Power fail without and with hold; oscillator forced on at power-up
    wr(8'h4b, 8'h00);
    wr(8'h4a, 8'h00);
    check(16'({sq, pwr_oe}), 16'h0001);
    vcc <= 1'b0;
    wait_bit(4, 10);
    @(posedge clk_i);
    vcc <= 1'b1;
    wait_bit(5, 40);
    rd(8'h4b, 8'h40);
    wr(8'h4b, 8'h48);
    wr(8'h4a, 8'h00);
    vcc <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(16'(pwr_oe), 16'h0001);
    vcc <= 1'b1;
    wr(8'h4a, 8'h08);
    done("power");
    // Wipe enabled: byte count, last index, flag and interrupt
    wr(8'h4b, 8'h54);
    wipe_n <= 1'b0;
    wait_bit(3, 10);
    n = 0;
    while (we === 1'b1 && n < 200)
    begin
      last = waddr;
      @(negedge clk_i);
      n++;
    end
    check(16'(n), 16'(`WIPE_BYTES));
    check(16'(last), 16'h0071);
    wait_bit(1, 6);
    rd(8'h4a, 8'h8c);
    wipe_n <= 1'b1;
    wr(8'h4a, 8'h08);
    check(16'(irq_oe), 16'h0000);
    wr(8'h4b, 8'h40);
    wipe_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    wipe_n <= 1'b1;
    rd(8'h4a, 8'h88);
    done("wipe");
    // Update lead time and pending status
    upd_req <= 1'b1;
    @(posedge clk_i);
    upd_req <= 1'b0;
    wait_bit(2, 1300);
    // Count starts in the first lead cycle; the go cycle is the last one
    check(16'(n + 1), 16'(`UPD_LEAD_CYC));
    rd(8'h4a, 8'hc8);
    upd_done <= 1'b1;
    @(posedge clk_i);
    upd_done <= 1'b0;
    rd(8'h4a, 8'h88);
    done("update");
    // Burst increments only on the data register with enable set
    wr(8'h4a, 8'h28);
    base = inc_cnt;
    host_bus_model_inst.bus_read(8'h53, d, h);
    wr(8'h53, 8'h11);
    rd(8'h4a, 8'ha8);
    check(16'(inc_cnt - base), 16'h0002);
    wr(8'h4a, 8'h08);
    base = inc_cnt;
    wr(8'h53, 8'h22);
    repeat (4) @(posedge clk_i);
    check(16'(inc_cnt - base), 16'h0000);
    // Bank not selected: no answer
    bank <= 1'b0;
    host_bus_model_inst.bus_read(8'h4a, d, h);
    check(16'(h), 16'h0000);
    bank <= 1'b1;
    done("burst");
    // Second reset in mid-run with the battery gone
    aux_bat <= 1'b0;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'h4a, 8'h08);
    rd(8'h4b, 8'h40);
    check(16'({aux_en, xtal}), 16'h0000);
    done("reset");
    print_verdict();
  end
endmodule // rtc_extended_control_and_smi_stack_tb_top
`default_nettype wire
